/* usp_top.sv */
// Notes on behaviour
// [R1] Two mode bits pick shift, 8-bit variable, 9-bit fixed or 9-bit variable.
// [R2] Nine-bit modes with filter set: no receive-done when ninth bit is zero.
// [R3] Eight-bit mode with filter set: receive-done only on a valid stop bit.
// [R4] Software keeps the filter bit clear while in shift-register mode.
// [R5] Receive enable is software writable; clearing it stops reception, in shift mode once the current byte ends.
// [R6] Nine-bit modes send the software ninth transmit bit as ninth data bit.
// [R7] Nine-bit modes store the received ninth bit; shift mode leaves it.
// [R8] Eight-bit mode with filter clear stores the received stop bit.
// [R9] Transmit-done sets after bit eight in shift mode, else at stop start.
// [R10] Receive-done sets after bit eight in shift mode, else mid stop bit.
// [R11] Variable-rate modes take a sixteen-times rate tick from an input.
// [R12] Eight-bit frame: zero start, eight data bits LSB first, one stop.
// [R13] Shift mode moves eight bits LSB first on rxd, clock on txd.
// [R14] A write to the serial buffer starts a transmission in every mode.
// [R15] Shift mode receives when receive-done is clear and enable is set.
`timescale 1ns/100ps
`include "usp_map.svh"
`default_nettype none

module usp_top
	import usp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rateTick,
	input wire logic rxdIn,
	output logic rxdOut,
	output logic rxdOeB,
	output logic txdOut,
	output logic irq
);

	logic [7:0] ctrl_q;
	logic [7:0] rxBuf_q;
	logic [1:0] irqStat_q;
	logic [1:0] irqMask_q;
	logic cfgDouble_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic txd_q;
	logic rxdOut_q;
	logic rxdOeB_q;
	logic [2:0] rxSync_q;
	logic rxLevel_q;
	logic rxPrev_q;
	logic [1:0] pre_q;
	logic m0Busy_q;
	logic m0Tx_q;
	logic [3:0] m0Phase_q;
	logic [2:0] m0Bit_q;
	logic [7:0] m0Shift_q;
	logic txBusy_q;
	logic [10:0] txFrame_q;
	logic [3:0] txTick_q;
	logic [3:0] txBit_q;
	logic [3:0] txLast_q;
	usp_rx_state_e rxState_q;
	logic [3:0] rxTick_q;
	logic [3:0] rxBit_q;
	logic [8:0] rxShift_q;

	usp_mode_e mode;
	logic nineBit;
	logic access;
	logic wrEn;
	logic rdEn;
	logic mapped;
	logic ctrlWr;
	logic bufWr;
	logic statRd;
	logic tick16;
	logic m0End;
	logic tiSet;
	logic riSet;
	logic rxAccept;
	logic rxNinthNew;
	logic [1:0] preLimit;
	logic [3:0] nDataBits;

	assign mode = usp_mode_e'(ctrl_q[`USP_CTRL_MODE_HI:`USP_CTRL_MODE_LO]);
	assign nineBit = (mode == USP_MODE_FIX9) || (mode == USP_MODE_VAR9);
	assign access = psel && penable && pready_q;
	assign wrEn = access && pwrite && !pslverr_q;
	assign rdEn = access && !pwrite && !pslverr_q;
	assign mapped = (paddr == `USP_ADDR_CTRL) || (paddr == `USP_ADDR_BUF) ||
		(paddr == `USP_ADDR_IRQ_STAT) || (paddr == `USP_ADDR_IRQ_MASK) ||
		(paddr == `USP_ADDR_CFG);
	assign ctrlWr = wrEn && (paddr == `USP_ADDR_CTRL);
	assign bufWr = wrEn && (paddr == `USP_ADDR_BUF); // see [R14]
	assign statRd = rdEn && (paddr == `USP_ADDR_IRQ_STAT);
	assign nDataBits = nineBit ? 4'h9 : 4'h8;

	// Mode 2 divides the core clock itself; modes 1 and 3 trust the rate input.
	assign preLimit = cfgDouble_q ? 2'(`USP_M2_FAST_PRE - 1) :
		2'(`USP_M2_SLOW_PRE - 1);
	always_comb begin
		unique case (mode) // see [R1]
			USP_MODE_SHIFT: tick16 = 1'b0;
			USP_MODE_ASYNC8: tick16 = rateTick; // see [R11]
			USP_MODE_FIX9: tick16 = (pre_q == preLimit);
			USP_MODE_VAR9: tick16 = rateTick; // see [R11]
		endcase
	end

	assign m0End = m0Busy_q && (m0Phase_q == 4'(`USP_M0_DIV - 1)) &&
		(m0Bit_q == 3'h7);
	assign tiSet = (m0End && m0Tx_q) || // see [R9]
		(txBusy_q && tick16 && (txTick_q == 4'hF) &&
		(txBit_q == txLast_q - 4'h2));

	// Stop-bit centre decides whether the frame is handed to software.
	assign rxNinthNew = nineBit ? rxShift_q[8] : rxLevel_q;
	always_comb begin
		rxAccept = 1'b0;
		if ((rxState_q == USP_RX_STOP) && tick16 && (rxTick_q == 4'hF) &&
			!ctrl_q[`USP_CTRL_RX_DONE]) begin
			if (nineBit) begin
				rxAccept = !ctrl_q[`USP_CTRL_FILTER] || rxShift_q[8]; // see [R2]
			end else begin
				rxAccept = !ctrl_q[`USP_CTRL_FILTER] || rxLevel_q; // see [R3]
			end
		end
	end
	assign riSet = (m0End && !m0Tx_q) || rxAccept; // see [R10]

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
			if (psel && !penable) begin
				prdata_q <= 32'h0;
				unique case (paddr)
					`USP_ADDR_CTRL: prdata_q[7:0] <= ctrl_q;
					`USP_ADDR_BUF: prdata_q[7:0] <= rxBuf_q;
					`USP_ADDR_IRQ_STAT: prdata_q[1:0] <= irqStat_q;
					`USP_ADDR_IRQ_MASK: prdata_q[1:0] <= irqMask_q;
					`USP_ADDR_CFG: prdata_q[0] <= cfgDouble_q;
					default: prdata_q <= 32'h0;
				endcase
			end
		end
	end

	// Hardware sets of the done flags win over a software write of zero.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl_q <= `USP_CTRL_RST;
		end else begin
			if (ctrlWr) begin
				ctrl_q[7:2] <= pwdata[7:2]; // see [R1] [R5]
			end
			if (rxAccept) begin
				ctrl_q[`USP_CTRL_RX_NINTH] <= rxNinthNew; // see [R7] [R8]
			end
			ctrl_q[`USP_CTRL_TX_DONE] <= tiSet ||
				(ctrlWr ? pwdata[`USP_CTRL_TX_DONE] : ctrl_q[`USP_CTRL_TX_DONE]);
			ctrl_q[`USP_CTRL_RX_DONE] <= riSet ||
				(ctrlWr ? pwdata[`USP_CTRL_RX_DONE] : ctrl_q[`USP_CTRL_RX_DONE]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irqMask_q <= `USP_IRQ_RST;
			cfgDouble_q <= `USP_CFG_RST;
		end else if (wrEn) begin
			if (paddr == `USP_ADDR_IRQ_MASK) begin
				irqMask_q <= pwdata[1:0];
			end
			if (paddr == `USP_ADDR_CFG) begin
				cfgDouble_q <= pwdata[`USP_CFG_DOUBLE];
			end
		end
	end

	// Only bits that were returned by the read are cleared, so no event is lost.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irqStat_q <= `USP_IRQ_RST;
			irq_q <= 1'b0;
		end else begin
			irqStat_q <= (statRd ? (irqStat_q & ~prdata_q[1:0]) : irqStat_q) |
				{tiSet, riSet};
			irq_q <= |(irqStat_q & irqMask_q);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rxSync_q <= 3'h7;
			rxLevel_q <= 1'b1;
			rxPrev_q <= 1'b1;
		end else begin
			rxSync_q <= {rxSync_q[1:0], rxdIn};
			if (rxSync_q[1] == rxSync_q[2]) begin
				rxLevel_q <= rxSync_q[2];
			end
			rxPrev_q <= rxLevel_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pre_q <= 2'h0;
		end else if (pre_q >= preLimit) begin
			pre_q <= 2'h0;
		end else begin
			pre_q <= pre_q + 2'h1;
		end
	end

	// Shift mode: one engine serves both directions because they share rxd.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			m0Busy_q <= 1'b0;
			m0Tx_q <= 1'b0;
			m0Phase_q <= 4'h0;
			m0Bit_q <= 3'h0;
			m0Shift_q <= 8'h00;
		end else if (!m0Busy_q) begin
			m0Phase_q <= 4'h0;
			m0Bit_q <= 3'h0;
			if (mode == USP_MODE_SHIFT && bufWr) begin
				m0Busy_q <= 1'b1; // see [R13] [R14]
				m0Tx_q <= 1'b1;
				m0Shift_q <= pwdata[7:0];
			end else if (mode == USP_MODE_SHIFT && ctrl_q[`USP_CTRL_RX_EN] &&
				!ctrl_q[`USP_CTRL_RX_DONE]) begin
				m0Busy_q <= 1'b1; // see [R15]
				m0Tx_q <= 1'b0;
			end
		end else if (m0Phase_q == 4'(`USP_M0_DIV - 1)) begin
			m0Phase_q <= 4'h0;
			m0Bit_q <= m0Bit_q + 3'h1;
			m0Shift_q <= {m0Tx_q ? 1'b1 : rxLevel_q, m0Shift_q[7:1]}; // see [R13]
			if (m0Bit_q == 3'h7) begin
				m0Busy_q <= 1'b0;
			end
		end else begin
			m0Phase_q <= m0Phase_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			txBusy_q <= 1'b0;
			txFrame_q <= 11'h7FF;
			txTick_q <= 4'h0;
			txBit_q <= 4'h0;
			txLast_q <= 4'hA;
		end else if (!txBusy_q) begin
			txTick_q <= 4'h0;
			txBit_q <= 4'h0;
			if (mode != USP_MODE_SHIFT && bufWr) begin
				txBusy_q <= 1'b1; // see [R14]
				if (nineBit) begin
					txFrame_q <= {1'b1, ctrl_q[`USP_CTRL_TX_NINTH], pwdata[7:0],
						1'b0}; // see [R6]
					txLast_q <= 4'hB;
				end else begin
					txFrame_q <= {2'h3, pwdata[7:0], 1'b0}; // see [R12]
					txLast_q <= 4'hA;
				end
			end
		end else if (tick16) begin
			txTick_q <= txTick_q + 4'h1;
			if (txTick_q == 4'hF) begin
				txBit_q <= txBit_q + 4'h1;
				if (txBit_q == txLast_q - 4'h1) begin
					txBusy_q <= 1'b0;
				end
			end
		end
	end

	// Clearing receive enable abandons a frame already in progress.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rxState_q <= USP_RX_IDLE;
			rxTick_q <= 4'h0;
			rxBit_q <= 4'h0;
			rxShift_q <= 9'h000;
		end else if (!ctrl_q[`USP_CTRL_RX_EN] || mode == USP_MODE_SHIFT) begin
			rxState_q <= USP_RX_IDLE; // see [R5]
		end else begin
			unique case (rxState_q)
				USP_RX_IDLE: begin
					rxTick_q <= 4'h0;
					rxBit_q <= 4'h0;
					if (rxPrev_q && !rxLevel_q) begin
						rxState_q <= USP_RX_START;
					end
				end
				USP_RX_START: begin
					if (tick16) begin
						rxTick_q <= rxTick_q + 4'h1;
						if (rxTick_q == 4'h7) begin
							rxTick_q <= 4'h0;
							rxState_q <= rxLevel_q ? USP_RX_IDLE : USP_RX_DATA;
						end
					end
				end
				USP_RX_DATA: begin
					if (tick16) begin
						rxTick_q <= rxTick_q + 4'h1;
						if (rxTick_q == 4'hF) begin
							rxShift_q[rxBit_q] <= rxLevel_q; // see [R12] [R11]
							rxBit_q <= rxBit_q + 4'h1;
							if (rxBit_q == nDataBits - 4'h1) begin
								rxState_q <= USP_RX_STOP;
							end
						end
					end
				end
				USP_RX_STOP: begin
					if (tick16) begin
						rxTick_q <= rxTick_q + 4'h1;
						if (rxTick_q == 4'hF) begin
							rxState_q <= USP_RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rxBuf_q <= 8'h00;
		end else if (m0End && !m0Tx_q) begin
			rxBuf_q <= {rxLevel_q, m0Shift_q[7:1]};
		end else if (rxAccept) begin
			rxBuf_q <= rxShift_q[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			txd_q <= 1'b1;
			rxdOut_q <= 1'b1;
			rxdOeB_q <= 1'b1;
		end else if (mode == USP_MODE_SHIFT) begin
			txd_q <= !m0Busy_q || (m0Phase_q >= 4'(`USP_M0_HALF)); // see [R13]
			rxdOut_q <= m0Busy_q && m0Tx_q ? m0Shift_q[0] : 1'b1;
			rxdOeB_q <= !(m0Busy_q && m0Tx_q);
		end else begin
			txd_q <= txBusy_q ? txFrame_q[txBit_q] : 1'b1;
			rxdOut_q <= 1'b1;
			rxdOeB_q <= 1'b1;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign txdOut = txd_q;
	assign rxdOut = rxdOut_q;
	assign rxdOeB = rxdOeB_q;

endmodule : usp_top

`default_nettype wire

/* usp_map.svh */
`ifndef USP_MAP_SVH
`define USP_MAP_SVH

// Register byte addresses on the APB port.
`define USP_ADDR_CTRL 8'h00
`define USP_ADDR_BUF 8'h04
`define USP_ADDR_IRQ_STAT 8'h08
`define USP_ADDR_IRQ_MASK 8'h0C
`define USP_ADDR_CFG 8'h10

// Serial port control field positions.
`define USP_CTRL_MODE_HI 7
`define USP_CTRL_MODE_LO 6
`define USP_CTRL_FILTER 5
`define USP_CTRL_RX_EN 4
`define USP_CTRL_TX_NINTH 3
`define USP_CTRL_RX_NINTH 2
`define USP_CTRL_TX_DONE 1
`define USP_CTRL_RX_DONE 0

// Interrupt status and mask field positions.
`define USP_IRQ_RX 0
`define USP_IRQ_TX 1

// Configuration field positions.
`define USP_CFG_DOUBLE 0

// Reset values.
`define USP_CTRL_RST 8'h00
`define USP_IRQ_RST 2'h0
`define USP_CFG_RST 1'h0

// Timing counts in core clock cycles, except USP_OVS in rate ticks per bit.
`define USP_M0_DIV 12
`define USP_M0_HALF 6
`define USP_OVS 16
`define USP_M2_SLOW_DIV 64
`define USP_M2_FAST_DIV 32
`define USP_M2_SLOW_PRE (`USP_M2_SLOW_DIV / `USP_OVS)
`define USP_M2_FAST_PRE (`USP_M2_FAST_DIV / `USP_OVS)

`endif

/* usp_pkg.sv */
package usp_pkg;

	typedef enum logic [1:0] {
		USP_MODE_SHIFT = 2'h0,
		USP_MODE_ASYNC8 = 2'h1,
		USP_MODE_FIX9 = 2'h2,
		USP_MODE_VAR9 = 2'h3
	} usp_mode_e;

	typedef enum logic [1:0] {
		USP_RX_IDLE = 2'h0,
		USP_RX_START = 2'h1,
		USP_RX_DATA = 2'h3,
		USP_RX_STOP = 2'h2
	} usp_rx_state_e;

endpackage : usp_pkg

/* usp_top_assertions.sv */
`timescale 1ns/100ps
`include "usp_map.svh"
`default_nettype none

module usp_checker (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txdOut,
	input wire logic rxdOeB,
	input wire logic irq
);
	logic [1:0] mode_q;
	logic [9:0] hiCnt_q;
	logic wrDone;
	assign wrDone = psel && penable && pready && pwrite;
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mode_q <= 2'h0;
		end else if (wrDone && paddr == `USP_ADDR_CTRL) begin
			mode_q <= pwdata[7:6];
		end
	end
	// A long high run on the line is the only sign seen here of an idle sender.
	always_ff @(posedge core_clk) begin
		if (!rst_b || !txdOut) begin
			hiCnt_q <= 10'h000;
		end else if (hiCnt_q != 10'h3FF) begin
			hiCnt_q <= hiCnt_q + 10'h001;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > `USP_ADDR_CFG))
		else $error("pslverr wrong for address");
	a_err_data: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0) else $error("unmapped read not zero");
	a_oe_shift: assert property (mode_q != 2'h0 |-> rxdOeB)
		else $error("rxd driven outside shift mode");
	a_shift_clock: assert property (mode_q == 2'h0 && $fell(txdOut)
		|=> !txdOut [*5] ##1 txdOut) else $error("shift clock shape");
	a_frame_start: assert property (wrDone && paddr == `USP_ADDR_BUF
		&& mode_q != 2'h0 && hiCnt_q > 10'h2BC |-> ##[1:4] !txdOut)
		else $error("frame did not start");
	a_irq_masked: assert property (wrDone && paddr == `USP_ADDR_IRQ_MASK
		&& pwdata[1:0] == 2'h0 |-> ##2 !irq [*4])
		else $error("irq high while masked");
endmodule : usp_checker

bind usp_top usp_checker u_chk (.core_clk, .rst_b, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txdOut,
	.rxdOeB, .irq);

`default_nettype wire

/* usp_far_end.sv */
`timescale 1ns/100ps
`default_nettype none

module usp_far_end #(
	parameter int BitLen = 32
) (
	input wire logic core_clk,
	input wire logic txdIn,
	input wire logic rxdOut,
	input wire logic rxdOeB,
	input wire logic listen,
	output logic rxd
);
	logic [10:0] got;
	logic [7:0] m0;
	logic [7:0] m0Src = 8'hFF;
	logic [3:0] m0Left = 4'h0;
	initial rxd = 1'b1;
	task automatic feed(input logic [7:0] d);
		m0Src = d;
		m0Left = 4'h8;
	endtask : feed
	// A shift-mode bit changes on the falling clock so it is settled at the rise.
	always @(negedge txdIn) begin
		if (m0Left != 4'h0) begin
			rxd <= m0Src[0];
			m0Src = {1'b1, m0Src[7:1]};
			m0Left = m0Left - 4'h1;
		end
	end
	// The line returns high after each frame, like a pulled-up idle line.
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (BitLen) @(posedge core_clk);
		end
		rxd <= 1'b1;
	endtask : send
	// Eleven mid-bit samples cover both the ten and eleven bit frames.
	always begin : rxFrame
		@(negedge txdIn);
		if (listen) begin
			repeat (BitLen / 2) @(posedge core_clk);
			for (int i = 0; i < 11; i++) begin
				got[i] = txdIn;
				repeat (BitLen) @(posedge core_clk);
			end
		end
	end
	always @(posedge txdIn) begin
		if (!rxdOeB) begin
			m0 <= {rxdOut, m0[7:1]};
		end
	end
endmodule : usp_far_end

`default_nettype wire

/* test_uart_serial_port_control.sv */
`timescale 1ns/100ps
`include "usp_map.svh"
`default_nettype none

module test_uart_serial_port_control;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rxdOut, rxdOeB, txdOut, irq, farRxd, rerr;
	logic rateTick = 1'b0, listen = 1'b0;
	wire logic rxdIn;
	int nFail = 0, nChecks = 0;
	assign rxdIn = rxdOeB ? farRxd : rxdOut;
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) rateTick <= ~rateTick;
	usp_top i_dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rateTick, .rxdIn, .rxdOut,
		.rxdOeB, .txdOut, .irq);
	usp_far_end far (.core_clk, .txdIn(txdOut), .rxdOut, .rxdOeB,
		.listen, .rxd(farRxd));
	task automatic endSim();
		if (nFail == 0 && nChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : endSim
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		nChecks++;
		if (g !== e) begin
			nFail++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	task automatic waitIrq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (irq !== 1'b1) begin
			nFail++;
		end
	endtask : waitIrq
	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(`USP_ADDR_CTRL, 32'h0);
		rd(`USP_ADDR_IRQ_MASK, 32'h0);
		rd(8'h14, 32'h0);
		chk(32'(rerr), 32'h1);
		for (int m = 0; m < 4; m++) begin
			wr(`USP_ADDR_CTRL, {24'h0, 2'(m), 6'h08});
			rd(`USP_ADDR_CTRL, {24'h0, 2'(m), 6'h08});
		end
		wr(`USP_ADDR_IRQ_MASK, 32'h3);
		wr(`USP_ADDR_CTRL, 32'h50);
		listen <= 1'b1;
		wr(`USP_ADDR_BUF, 32'hA5);
		waitIrq();
		chk(32'(irq), 32'h1);
		rd(`USP_ADDR_CTRL, 32'h52);
		rd(`USP_ADDR_IRQ_STAT, 32'h2);
		rd(`USP_ADDR_IRQ_STAT, 32'h0);
		repeat (400) @(posedge core_clk);
		chk(32'(far.got), 32'({2'h3, 8'hA5, 1'h0}));
		wr(`USP_ADDR_CTRL, 32'h50);
		far.send({2'h3, 8'h3C, 1'h0});
		waitIrq();
		rd(`USP_ADDR_CTRL, 32'h55);
		rd(`USP_ADDR_BUF, 32'h3C);
		rd(`USP_ADDR_IRQ_STAT, 32'h1);
		wr(`USP_ADDR_CTRL, 32'h70);
		far.send({2'h2, 8'h11, 1'h0});
		repeat (40) @(posedge core_clk);
		rd(`USP_ADDR_CTRL, 32'h70);
		wr(`USP_ADDR_CTRL, 32'hF0);
		far.send({2'h2, 8'h55, 1'h0});
		repeat (40) @(posedge core_clk);
		rd(`USP_ADDR_CTRL, 32'hF0);
		far.send({2'h3, 8'h81, 1'h0});
		waitIrq();
		rd(`USP_ADDR_CTRL, 32'hF5);
		rd(`USP_ADDR_BUF, 32'h81);
		rd(`USP_ADDR_IRQ_STAT, 32'h1);
		wr(`USP_ADDR_CTRL, 32'hD0);
		wr(`USP_ADDR_BUF, 32'h3C);
		waitIrq();
		rd(`USP_ADDR_CTRL, 32'hD2);
		repeat (400) @(posedge core_clk);
		chk(32'(far.got), 32'({2'h2, 8'h3C, 1'h0}));
		rd(`USP_ADDR_IRQ_STAT, 32'h2);
		wr(`USP_ADDR_CTRL, 32'hC0);
		far.send({2'h3, 8'h66, 1'h0});
		repeat (40) @(posedge core_clk);
		rd(`USP_ADDR_CTRL, 32'hC0);
		rd(`USP_ADDR_IRQ_STAT, 32'h0);
		listen <= 1'b0;
		wr(`USP_ADDR_CTRL, 32'h00);
		wr(`USP_ADDR_IRQ_MASK, 32'h0);
		wr(`USP_ADDR_BUF, 32'h96);
		repeat (200) @(posedge core_clk);
		chk(32'(irq), 32'h0);
		chk(32'(far.m0), 32'h96);
		rd(`USP_ADDR_CTRL, 32'h02);
		rd(`USP_ADDR_IRQ_STAT, 32'h2);
		far.feed(8'hC3);
		wr(`USP_ADDR_CTRL, 32'h10);
		repeat (200) @(posedge core_clk);
		rd(`USP_ADDR_CTRL, 32'h11);
		rd(`USP_ADDR_BUF, 32'hC3);
		rd(`USP_ADDR_IRQ_STAT, 32'h1);
		wr(`USP_ADDR_CFG, 32'h1);
		rd(`USP_ADDR_CFG, 32'h1);
		wr(`USP_ADDR_CTRL, 32'h98);
		far.send({2'h3, 8'h5A, 1'h0});
		repeat (40) @(posedge core_clk);
		rd(`USP_ADDR_CTRL, 32'h9D);
		rd(`USP_ADDR_BUF, 32'h5A);
		listen <= 1'b1;
		wr(`USP_ADDR_BUF, 32'h0F);
		repeat (400) @(posedge core_clk);
		chk(32'(far.got), 32'({2'h3, 8'h0F, 1'h0}));
		rd(`USP_ADDR_CTRL, 32'h9F);
		endSim();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		nFail++;
		endSim();
	end
endmodule : test_uart_serial_port_control

`default_nettype wire
